// >>> dmxrp_desk.sv
module dmxrp_desk
  import dmxrp_pkg::*;
(
  input logic clk,
  output logic slotValid,
  output logic [SLOT_W-1:0] slotNum,
  output logic [CHAN_W-1:0] slotData
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap = 0;
  initial begin
    slotValid = 1'b0;
    slotNum = '0;
    slotData = '0;
  end
  // a slow desk leaves idle cycles between slots
  task automatic send(input logic [SLOT_W-1:0] n, input logic [7:0] v);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    slotValid <= 1'b1;
    slotNum <= n;
    slotData <= v;
    @(posedge clk);
    slotValid <= 1'b0;
    // stale lines must not look like the last slot
    slotNum <= ~n;
    slotData <= ~v;
  endtask : send
endmodule : dmxrp_desk

// >>> dmxrp_pkg.sv
package dmxrp_pkg;

  localparam int CHAN_W = 8;
  localparam int POS_W = 16;
  localparam int SLOT_W = 9;
  localparam int NUM_CHAN = 6;

  // channel order inside the six-slot footprint
  localparam int CH_ROUGH = 0;
  localparam int CH_FINE = 1;
  localparam int CH_SPEED = 2;
  localparam int CH_SAVE = 3;
  localparam int CH_UP = 4;
  localparam int CH_DOWN = 5;

  localparam logic [CHAN_W-1:0] CHAN_FULL = 8'hff;
  localparam int PCT_FULL = 100;
  localparam logic [6:0] SAVE_PCT_LO = 7'd60;
  localparam logic [6:0] SAVE_PCT_HI = 7'd65;

  // approach slowdown: speed limited to error >> this shift
  localparam int APPROACH_SHIFT = 4;

  localparam logic [POS_W-1:0] TOP_RESET = 16'hffff;
  localparam logic [POS_W-1:0] BOTTOM_RESET = 16'h0000;

  // lamp flashing half period
  localparam int CLK_MHZ = 250;
  localparam int FLASH_HALF_MS = 125;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;

  // register port
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h1;
  localparam logic [REG_AW-1:0] REG_POS = 4'h2;
  localparam logic [REG_AW-1:0] REG_TARGET = 4'h3;
  localparam logic [REG_AW-1:0] REG_TOP = 4'h4;
  localparam logic [REG_AW-1:0] REG_BOTTOM = 4'h5;
  localparam logic [REG_DW-1:0] CTRL_RESET = 16'h0000;
  localparam int CTRL_HOLD_BIT = 0;

  typedef struct packed {
    logic [CHAN_W-1:0] rough;
    logic [CHAN_W-1:0] fine;
    logic [CHAN_W-1:0] speed;
    logic [CHAN_W-1:0] save;
    logic [CHAN_W-1:0] up;
    logic [CHAN_W-1:0] down;
  } dmxrp_chan_t;

  typedef struct packed {
    logic run;
    logic up;
    logic [CHAN_W-1:0] speed;
  } dmxrp_motor_t;

  typedef enum logic [1:0] {
    DMXRP_IDLE,
    DMXRP_MANUAL,
    DMXRP_SEEK
  } dmxrp_state_t;

endpackage : dmxrp_pkg

// >>> dmxrp_position_ctrl.sv
module dmxrp_position_ctrl
  import dmxrp_pkg::*;
#(
  parameter int FLASH_CYC = FLASH_HALF_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slotValid,
  input wire logic [SLOT_W-1:0] slotNum,
  input wire logic [CHAN_W-1:0] slotData,
  input wire logic [SLOT_W-1:0] startAddr,
  input wire logic [POS_W-1:0] drumPos,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [REG_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_DW-1:0] regRdata,
  output dmxrp_motor_t motor,
  output logic lampOn
);

  function automatic logic [6:0] toPct(input logic [CHAN_W-1:0] v);
    logic [15:0] prod;
    prod = 16'(v) * 16'(PCT_FULL);
    return 7'(prod / 16'(CHAN_FULL));
  endfunction : toPct

  function automatic logic [CHAN_W-1:0] minByte(
    input logic [CHAN_W-1:0] a,
    input logic [CHAN_W-1:0] b
  );
    return (a < b) ? a : b;
  endfunction : minByte

  dmxrp_chan_t chan;

  dmxrp_slot_capture slotCapture (
    .clk(clk),
    .nrst(nrst),
    .slotValid(slotValid),
    .slotNum(slotNum),
    .slotData(slotData),
    .startAddr(startAddr),
    .chan(chan)
  );

  logic [REG_DW-1:0] ctrl;
  logic [POS_W-1:0] topLimit;
  logic [POS_W-1:0] bottomLimit;
  logic upSeen;
  logic downSeen;
  dmxrp_state_t state;
  dmxrp_state_t next_state;
  logic [31:0] flashCnt;
  logic flashPhase;

  // channel decode
  wire [POS_W-1:0] rawTarget = {chan.rough, chan.fine};
  wire [6:0] savePct = toPct(chan.save);
  wire saveEn = (savePct >= SAVE_PCT_LO) && (savePct <= SAVE_PCT_HI);
  wire upActive = (chan.up != '0);
  wire downActive = (chan.down != '0);
  wire manualConflict = upActive && downActive;
  wire manualReq = upActive || downActive;
  wire brake = (chan.speed == '0) || ctrl[CTRL_HOLD_BIT];

  // target scaled into the taught range; bottom above top gives no range
  wire [POS_W-1:0] range = (topLimit >= bottomLimit) ?
                           topLimit - bottomLimit : '0;
  wire [2*POS_W-1:0] scaled = {16'h0000, range} * {16'h0000, rawTarget}
                              + {16'h0000, range};
  wire [POS_W-1:0] target = bottomLimit +
                            scaled[2*POS_W-1:POS_W];

  // distance to go and approach ramp
  wire targetAbove = target > drumPos;
  wire [POS_W-1:0] distance = targetAbove ? target - drumPos :
                              drumPos - target;
  wire [POS_W-1:0] rampWide = distance >> APPROACH_SHIFT;
  wire [CHAN_W-1:0] rampSpeed = (rampWide > POS_W'(CHAN_FULL)) ? CHAN_FULL :
                                (rampWide == '0) ? 8'h01 :
                                rampWide[CHAN_W-1:0];
  wire [CHAN_W-1:0] seekSpeed = minByte(chan.speed, rampSpeed);
  wire atTarget = (distance == '0);

  // manual speed follows its channel, still capped by the speed channel
  wire [CHAN_W-1:0] manualVal = upActive ? chan.up : chan.down;
  wire [CHAN_W-1:0] manualSpeed = minByte(manualVal, chan.speed);

  // teaching: capture on the fall of a manual channel to zero
  wire upReleased = upSeen && !upActive;
  wire downReleased = downSeen && !downActive;
  wire storeTop = saveEn && upReleased;
  wire storeBottom = saveEn && downReleased;

  always_comb begin
    next_state = state;
    unique case (state)
      DMXRP_IDLE: begin
        if (manualReq) begin
          next_state = DMXRP_MANUAL;
        end else if (!atTarget && !brake) begin
          next_state = DMXRP_SEEK;
        end
      end
      DMXRP_MANUAL: begin
        // released, with saving on or off: return to commanded target
        if (!manualReq) begin
          next_state = DMXRP_IDLE;
        end
      end
      DMXRP_SEEK: begin
        if (manualReq) begin
          next_state = DMXRP_MANUAL;
        end else if (atTarget || brake) begin
          next_state = DMXRP_IDLE;
        end
      end
    endcase
  end

  // motor command for next cycle
  dmxrp_motor_t next_motor;
  always_comb begin
    next_motor = '0;
    if (!brake) begin
      if (state == DMXRP_MANUAL && manualReq && !manualConflict) begin
        next_motor.run = 1'b1;
        next_motor.up = upActive;
        next_motor.speed = manualSpeed;
      end else if (state == DMXRP_SEEK && !manualReq && !atTarget) begin
        // positioning carries on whatever the save channel says
        next_motor.run = 1'b1;
        next_motor.up = targetAbove;
        next_motor.speed = seekSpeed;
      end
    end
  end

  wire travelling = next_motor.run || motor.run;
  wire flashTick = (flashCnt == 32'(FLASH_CYC - 1));
  wire next_lamp = travelling ? flashPhase :
                   (atTarget && !manualReq);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= DMXRP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      motor <= '0;
      lampOn <= 1'b0;
    end else begin
      motor <= next_motor;
      lampOn <= next_lamp;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flashCnt <= '0;
      flashPhase <= 1'b0;
    end else if (!travelling) begin
      // restart so every move from rest begins with the lamp on for a full half period
      flashCnt <= '0;
      flashPhase <= 1'b1;
    end else if (flashTick) begin
      flashCnt <= '0;
      flashPhase <= !flashPhase;
    end else begin
      flashCnt <= flashCnt + 32'd1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upSeen <= 1'b0;
      downSeen <= 1'b0;
    end else begin
      upSeen <= upActive;
      downSeen <= downActive;
    end
  end

  // limits survive until taught again or reset; no other path writes them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      topLimit <= TOP_RESET;
      bottomLimit <= BOTTOM_RESET;
    end else begin
      if (storeTop) begin
        topLimit <= drumPos;
      end
      if (storeBottom) begin
        bottomLimit <= drumPos;
      end
    end
  end

  // register port
  wire ctrlWrite = regWr && (regAddr == REG_CTRL);
  wire [REG_DW-1:0] statusWord = {10'h000, saveEn, lampOn, atTarget,
                                  motor.up, motor.run, brake};
  logic [REG_DW-1:0] readMux;
  always_comb begin
    unique case (regAddr)
      REG_CTRL: readMux = ctrl;
      REG_STATUS: readMux = statusWord;
      REG_POS: readMux = drumPos;
      REG_TARGET: readMux = target;
      REG_TOP: readMux = topLimit;
      REG_BOTTOM: readMux = bottomLimit;
      default: readMux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
    end else if (ctrlWrite) begin
      ctrl <= regWdata & 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRd ? readMux : '0;
    end
  end

endmodule : dmxrp_position_ctrl

// >>> dmxrp_position_ctrl_sva.sv
module dmxrp_position_ctrl_sva
  import dmxrp_pkg::*;
(
  input logic clk,
  input logic nrst,
  input logic slotValid,
  input logic [SLOT_W-1:0] slotNum,
  input logic [CHAN_W-1:0] slotData,
  input logic [SLOT_W-1:0] startAddr,
  input logic [POS_W-1:0] drumPos,
  input logic regRd,
  input logic [REG_AW-1:0] regAddr,
  input logic [REG_DW-1:0] regRdata,
  input dmxrp_motor_t motor
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [CHAN_W-1:0] spd, up, dn;
  // one bit wider so slots below the start wrap high, as in the design
  wire [SLOT_W:0] rel = {1'b0, slotNum} - {1'b0, startAddr};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spd <= '0;
      up <= '0;
      dn <= '0;
    end else if (slotValid) begin
      if (rel == (SLOT_W+1)'(CH_SPEED)) spd <= slotData;
      if (rel == (SLOT_W+1)'(CH_UP)) up <= slotData;
      if (rel == (SLOT_W+1)'(CH_DOWN)) dn <= slotData;
    end
  end
  sequence s_upHeld;
    (up != 0 && dn == 0 && $stable(up) && $stable(spd))[*3];
  endsequence
  sequence s_dnHeld;
    (dn != 0 && up == 0 && $stable(dn) && $stable(spd))[*3];
  endsequence
  chk_brake_stop: assert property ((spd == 0)[*3] |-> !motor.run)
    else $error("motor runs with speed channel zero");
  chk_both_stop: assert property ((up != 0 && dn != 0)[*3] |-> !motor.run)
    else $error("motor runs with both manual channels set");
  chk_manual_up: assert property (s_upHeld ##0 motor.run |-> motor.up &&
    motor.speed == (up < spd ? up : spd)) else $error("manual up wrong");
  chk_manual_dn: assert property (s_dnHeld ##0 motor.run |-> !motor.up &&
    motor.speed == (dn < spd ? dn : spd)) else $error("manual down wrong");
  chk_speed_cap: assert property ($stable(spd)[*3] ##0 motor.run |->
    motor.speed != 0 && motor.speed <= spd) else $error("speed over cap");
  chk_idle_quiet: assert property (!motor.run |-> motor.speed == 0 && !motor.up)
    else $error("stopped motor shows speed or direction");
  chk_rd_idle: assert property (!regRd |=> regRdata == 0)
    else $error("read data outside read cycle");
  chk_rd_pos: assert property (regRd && regAddr == REG_POS |=>
    regRdata == $past(drumPos)) else $error("position read wrong");
endmodule : dmxrp_position_ctrl_sva
bind dmxrp_position_ctrl dmxrp_position_ctrl_sva i_sva (.clk, .nrst,
  .slotValid, .slotNum, .slotData, .startAddr, .drumPos, .regRd, .regAddr,
  .regRdata, .motor);

// >>> dmxrp_position_ctrl_tb_top.sv
module dmxrp_position_ctrl_tb_top
  import dmxrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FC = 8;
  localparam logic [SLOT_W-1:0] SA = 9'h0d4;
  logic clk = 0, nrst = 0, regWr = 0, regRd = 0, lampOn, slotValid;
  logic [SLOT_W-1:0] slotNum, startAddr = SA;
  logic [CHAN_W-1:0] slotData;
  logic [POS_W-1:0] drumPos = '0;
  logic [REG_AW-1:0] regAddr = '0;
  logic [REG_DW-1:0] regWdata = '0, regRdata, rv;
  dmxrp_motor_t motor;
  int error_cnt = 0, cmp_count = 0, cyc = 0, top = 65535, bot = 0, hold = 0;
  int chv[6];
  int sv[4] = '{152, 169, 153, 168};
  logic [3:0] ra[4] = '{REG_CTRL, REG_TOP, REG_BOTTOM, 4'hf};
  logic [15:0] re[4] = '{16'h0000, 16'hffff, 16'h0000, 16'h0000};
  logic [15:0] lf = 16'h0041;
  always #2 clk = ~clk;
  dmxrp_desk i_desk (.clk, .slotValid, .slotNum, .slotData);
  dmxrp_position_ctrl #(.FLASH_CYC(FC)) i_dut (.clk, .nrst, .slotValid,
    .slotNum, .slotData, .startAddr, .drumPos, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .motor, .lampOn);
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  function automatic logic [15:0] tgt();
    longint r;
    r = (bot > top) ? 0 : longint'(top - bot) * (chv[0] * 256 + chv[1] + 1);
    return 16'(bot + (r >> 16));
  endfunction : tgt
  function automatic logic [9:0] expm();
    int e, s;
    if (chv[2] == 0 || hold || (chv[4] && chv[5])) return '0;
    if (chv[4]) return {2'b11, 8'(chv[4] < chv[2] ? chv[4] : chv[2])};
    if (chv[5]) return {2'b10, 8'(chv[5] < chv[2] ? chv[5] : chv[2])};
    e = int'(tgt()) - int'(drumPos);
    s = (e < 0 ? -e : e) >> 4;
    s = s > 255 ? 255 : (s < 1 ? 1 : s);
    if (e == 0) return '0;
    return {1'b1, e > 0, 8'(s < chv[2] ? s : chv[2])};
  endfunction : expm
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regWdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask : rd
  // limit capture is modelled on the release value, as the device sees it
  task automatic put(input int c, input int v);
    int pct;
    pct = chv[3] * 100 / 255;
    if (pct >= 60 && pct <= 65 && v == 0 && chv[c] != 0) begin
      if (c == 4) top = drumPos;
      if (c == 5) bot = drumPos;
    end
    chv[c] = v;
    i_desk.send(startAddr + 9'(c), 8'(v));
  endtask : put
  task automatic cmpall();
    repeat (4) @(posedge clk);
    #1 check(16'(motor), 16'(expm()));
    rd(REG_TARGET);
    check(rv, tgt());
    rd(REG_TOP);
    check(rv, 16'(top));
    rd(REG_BOTTOM);
    check(rv, 16'(bot));
  endtask : cmpall
  task automatic lamp(input int e);
    int h;
    h = 0;
    repeat (4 * FC) begin
      @(posedge clk);
      #1 h += (lampOn === 1'b1);
    end
    check(16'(h), 16'(e));
  endtask : lamp
  task automatic print_verdict();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    wr(REG_TOP, 16'h1234);
    foreach (ra[i]) begin
      rd(ra[i]);
      check(rv, re[i]);
    end
    for (int k = 0; k < 8; k++) begin
      i_desk.gap = lf[1:0];
      drumPos <= lf ^ 16'h5a5a;
      put(0, lf[7:0]);
      lf = nx(lf);
      put(1, lf[7:0]);
      lf = nx(lf);
      put(2, k == 3 ? 0 : (k == 4 ? 255 : lf[7:0]));
      cmpall();
    end
    put(2, 200);
    drumPos <= tgt() ^ 16'h8000;
    lamp(2 * FC);
    drumPos <= tgt() + 16'h0003;
    cmpall();
    drumPos <= tgt();
    cmpall();
    lamp(4 * FC);
    i_desk.send(SA + 9'd6, 8'h00);
    i_desk.send(SA - 9'd1, 8'h00);
    drumPos <= 16'h8000;
    cmpall();
    put(4, 50);
    cmpall();
    put(4, 0);
    cmpall();
    put(4, 9);
    put(5, 9);
    cmpall();
    put(5, 0);
    put(4, 0);
    foreach (sv[i]) begin
      put(3, sv[i]);
      drumPos <= 16'h4000 + 16'(sv[i]);
      cmpall();
      put(4, 77);
      cmpall();
      put(4, 30);
      put(4, 0);
      cmpall();
    end
    drumPos <= 16'h1000;
    put(5, 40);
    put(5, 0);
    put(3, 0);
    put(0, 255);
    put(1, 255);
    cmpall();
    put(0, 0);
    put(1, 0);
    cmpall();
    // off target, so the hold has a motion to stop
    drumPos <= 16'h2000;
    wr(REG_CTRL, 16'h0001);
    hold = 1;
    cmpall();
    rd(REG_STATUS);
    check(rv, 16'h0001);
    rd(REG_POS);
    check(rv, 16'h2000);
    wr(REG_CTRL, 16'h0000);
    hold = 0;
    cmpall();
    // mid-run reset: limits lost, new start address
    @(posedge clk);
    nrst <= 1'b0;
    startAddr <= 9'h100 + 9'(lf[6:0]);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chv = '{default: 0};
    top = 65535;
    bot = 0;
    @(posedge clk);
    #1 check(16'({lampOn, motor}), 16'h0000);
    put(2, 100);
    put(3, 160);
    drumPos <= 16'h7000;
    put(4, 20);
    put(4, 0);
    put(3, 0);
    i_desk.send(SA, 8'hff);
    cmpall();
    print_verdict();
  end
endmodule : dmxrp_position_ctrl_tb_top

// >>> dmxrp_slot_capture.sv
module dmxrp_slot_capture
  import dmxrp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic slotValid,
  input wire logic [SLOT_W-1:0] slotNum,
  input wire logic [CHAN_W-1:0] slotData,
  input wire logic [SLOT_W-1:0] startAddr,
  output dmxrp_chan_t chan
);

  logic [SLOT_W:0] offset;
  logic hit;
  logic [2:0] idx;

  // offset from start address; slots below the start wrap high and miss
  assign offset = {1'b0, slotNum} - {1'b0, startAddr};
  assign hit = slotValid && (offset < (SLOT_W+1)'(NUM_CHAN));
  assign idx = offset[2:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan <= '0;
    end else if (hit) begin
      unique case (idx)
        3'(CH_ROUGH): chan.rough <= slotData;
        3'(CH_FINE): chan.fine <= slotData;
        3'(CH_SPEED): chan.speed <= slotData;
        3'(CH_SAVE): chan.save <= slotData;
        3'(CH_UP): chan.up <= slotData;
        3'(CH_DOWN): chan.down <= slotData;
        default: chan <= chan;
      endcase
    end
  end

endmodule : dmxrp_slot_capture
